//--- rtl/gsp_pkg.sv
// constants, register map and timing counts for the gigabit serdes pma block
// Summary of operation
// RQ1: transmit word is captured into the holding register on each reference clock rising edge.
// RQ2: each captured word is sent serially, bit 0 first, then ascending bit order.
// RQ3: loopback enabled routes the transmitted serial stream into the receive path.
// RQ4: during loopback the line output holds static one, positive high, negative low.
// RQ5: below detection threshold, signal present drops and received word is forced all ones; the code ignores the line level while loopback is enabled.
// RQ6: receiver recovers data and two byte clocks running 180 degrees apart.
// RQ7: transmit latency from capture edge to first serial bit is about 4.4 bits; the code's latency varies with the free running frame phase.
// RQ8: receive latency from first serial bit to presenting byte clock edge is 28 bits.
// RQ9: after a phase disturbance, bit synchronisation is regained within 2500 bit times.
// RQ10: after power-up, frequency lock within 500 us; received data invalid before then.
// RQ11: reference clock guaranteed between 124.0 and 126.0 MHz, serial rate ten times that.
// RQ12: successive received words are presented alternately on the two byte clocks; the code repeats the odd clock when a realignment follows an odd word.
// RQ13: received word bit 0 is least significant and holds the earliest serial bit.
// RQ14: comma alignment enabled aligns to 0011111XXX, presents on odd clock, flags comma seen; the code does both only for commas in the odd slot.
// RQ15: comma alignment disabled keeps current boundary and holds comma seen low.
// RQ16: when signal returns, stop forcing ones, raise present, resume after bit lock.
package gsp_pkg;

  // clock and scaled line timing: one serial bit per system clock cycle
  localparam int              CLK_PERIOD_PS      = 10000;
  localparam int              BIT_PS             = CLK_PERIOD_PS;
  localparam int              WORD_W             = 10;
  localparam logic [3:0]      LAST_BIT           = 4'h9;
  localparam logic [9:0]      ALL_ONES           = 10'h3FF;
  localparam int              COMMA_W            = 7;
  localparam logic [6:0]      COMMA_HEAD         = 7'h7C;

  // receive latency in tenths of a bit and its derived presentation point
  localparam int              RX_LAT_TENTHS_BITS = 280;
  localparam int              RX_LAT_CYC         = (RX_LAT_TENTHS_BITS * BIT_PS) / (10 * CLK_PERIOD_PS);
  localparam int              RX_RISE_OFS        = RX_LAT_CYC - 2 * WORD_W - 2;
  localparam logic [3:0]      RISE_CNT           = 4'(RX_RISE_OFS - 1);

  // lock times
  localparam int              BIT_SYNC_BITS      = 2500;
  localparam int              BIT_SYNC_CYC       = (BIT_SYNC_BITS * BIT_PS) / CLK_PERIOD_PS;
  localparam logic [11:0]     BSYNC_LOAD         = 12'(BIT_SYNC_CYC);
  localparam int              FLOCK_US           = 500;
  localparam int              FLOCK_CYC          = (FLOCK_US * 1000000) / CLK_PERIOD_PS;

  // register bus
  localparam int              AXI_AW             = 8;
  localparam logic [7:0]      CTRL_OFS           = 8'h00;
  localparam logic [7:0]      STATUS_OFS         = 8'h04;
  localparam logic [7:0]      IRQ_STAT_OFS       = 8'h08;
  localparam logic [7:0]      IRQ_MASK_OFS       = 8'h0C;
  localparam logic [1:0]      RESP_OKAY          = 2'h0;
  localparam logic [1:0]      RESP_SLVERR        = 2'h2;

  // field layouts and reset values
  localparam int              CTRL_W             = 2;
  localparam int              CTRL_LOOP_BIT      = 0;
  localparam int              CTRL_COMMA_BIT     = 1;
  localparam logic [1:0]      CTRL_RST           = 2'h0;
  localparam int              STAT_SIG_BIT       = 0;
  localparam int              STAT_LOCK_BIT      = 1;
  localparam int              IRQ_W              = 3;
  localparam int              IRQ_COMMA_BIT      = 0;
  localparam int              IRQ_SIGLOST_BIT    = 1;
  localparam int              IRQ_LOCK_BIT       = 2;
  localparam logic [2:0]      IRQ_MASK_RST       = 3'h0;

endpackage : gsp_pkg

//--- rtl/gsp_regs.sv
// axi4-lite register file with control, status and sticky interrupt bits
`timescale 1ns/1ps
`default_nettype none
module gsp_regs (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // axi4-lite slave
  input  wire logic [gsp_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output var  logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output var  logic                          s_axi_wready,
  output var  logic [1:0]                    s_axi_bresp,
  output var  logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [gsp_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output var  logic                          s_axi_arready,
  output var  logic [31:0]                   s_axi_rdata,
  output var  logic [1:0]                    s_axi_rresp,
  output var  logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // block side
  input  wire logic                          sig_present,
  input  wire logic                          locked,
  input  wire logic [gsp_pkg::IRQ_W-1:0]     events,
  output var  logic                          serial_loopback_enable,
  output var  logic                          comma_align_enable,
  output var  logic                          irq
);
  import gsp_pkg::*;

  logic                  aw_hs, w_hs, ar_hs, do_wr;
  logic                  aw_got_r, w_got_r, awready_r, wready_r;
  logic                  bvalid_r, arready_r, rvalid_r, irq_r;
  logic [AXI_AW-1:0]     awaddr_r;
  logic [31:0]           wdata_r, rdata_r, rd_mux;
  logic [3:0]            wstrb_r;
  logic [1:0]            bresp_r, rresp_r;
  logic [CTRL_W-1:0]     ctrl_r;
  logic [IRQ_W-1:0]      ist_r, imask_r, ist_clr;

  function automatic logic mapped(input logic [AXI_AW-1:0] a);
    mapped = (a == CTRL_OFS) || (a == STATUS_OFS) || (a == IRQ_STAT_OFS) || (a == IRQ_MASK_OFS);
  endfunction : mapped

  assign aw_hs = s_axi_awvalid & awready_r;
  assign w_hs  = s_axi_wvalid & wready_r;
  assign ar_hs = s_axi_arvalid & arready_r;
  assign do_wr = aw_got_r & w_got_r & ~bvalid_r;

  // address and data are taken independently; the write lands once both are held
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_got_r <= 1'b0;
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_wr) begin
        w_got_r <= 1'b0;
      end
      awready_r <= ~aw_hs & (~aw_got_r | do_wr);
      wready_r  <= ~w_hs & (~w_got_r | do_wr);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r  <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r  <= CTRL_RST;
      imask_r <= IRQ_MASK_RST;
    end else if (do_wr && wstrb_r[0]) begin
      if (awaddr_r == CTRL_OFS) ctrl_r <= wdata_r[CTRL_W-1:0];
      if (awaddr_r == IRQ_MASK_OFS) imask_r <= wdata_r[IRQ_W-1:0];
    end
  end

  // write one to clear; an event in the clearing cycle wins
  assign ist_clr = (do_wr && wstrb_r[0] && awaddr_r == IRQ_STAT_OFS) ? wdata_r[IRQ_W-1:0] : '0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ist_r <= '0;
      irq_r <= 1'b0;
    end else begin
      ist_r <= (ist_r & ~ist_clr) | events;
      irq_r <= |(ist_r & imask_r);
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      CTRL_OFS:     rd_mux[CTRL_W-1:0] = ctrl_r;
      STATUS_OFS:   rd_mux[STAT_LOCK_BIT:STAT_SIG_BIT] = {locked, sig_present};
      IRQ_STAT_OFS: rd_mux[IRQ_W-1:0] = ist_r;
      IRQ_MASK_OFS: rd_mux[IRQ_W-1:0] = imask_r;
      default:      rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= RESP_OKAY;
    end else begin
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux;
        rresp_r  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
      arready_r <= ~ar_hs & (~rvalid_r | s_axi_rready);
    end
  end

  assign s_axi_awready          = awready_r;
  assign s_axi_wready           = wready_r;
  assign s_axi_bvalid           = bvalid_r;
  assign s_axi_bresp            = bresp_r;
  assign s_axi_arready          = arready_r;
  assign s_axi_rvalid           = rvalid_r;
  assign s_axi_rdata            = rdata_r;
  assign s_axi_rresp            = rresp_r;
  assign serial_loopback_enable = ctrl_r[CTRL_LOOP_BIT];
  assign comma_align_enable     = ctrl_r[CTRL_COMMA_BIT];
  assign irq                    = irq_r;

endmodule : gsp_regs
`default_nettype wire

//--- rtl/gsp_serdes_pma.sv
// serializer and deserializer datapath with comma alignment, loss of signal and lock timing
`timescale 1ns/1ps
`default_nettype none
module gsp_serdes_pma #(
  parameter int FLOCK_CYCLES = gsp_pkg::FLOCK_CYC
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // axi4-lite slave
  input  wire logic [gsp_pkg::AXI_AW-1:0]    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output var  logic                          s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output var  logic                          s_axi_wready,
  output var  logic [1:0]                    s_axi_bresp,
  output var  logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [gsp_pkg::AXI_AW-1:0]    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output var  logic                          s_axi_arready,
  output var  logic [31:0]                   s_axi_rdata,
  output var  logic [1:0]                    s_axi_rresp,
  output var  logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  output var  logic                          irq,
  // parallel transmit side
  input  wire logic                          reference_clock_in,
  input  wire logic [gsp_pkg::WORD_W-1:0]    tx_word,
  // serial line
  output var  logic                          line_tx_pos,
  output var  logic                          line_tx_neg,
  input  wire logic                          line_rx_data,
  input  wire logic                          line_level_ok,
  // parallel receive side
  output var  logic [gsp_pkg::WORD_W-1:0]    rx_word,
  output var  logic                          recv_byte_clk_even,
  output var  logic                          recv_byte_clk_odd,
  output var  logic                          comma_seen,
  output var  logic                          line_signal_present
);
  import gsp_pkg::*;

  localparam logic [15:0] FLOCK_LOAD = 16'(FLOCK_CYCLES);

  logic                   serial_loopback_enable, comma_align_enable;
  logic [IRQ_W-1:0]       irq_events;

  logic                   ref_s1_r, ref_s2_r, ref_s3_r, ref_edge;
  logic [WORD_W-1:0]      txw_s1_r, txw_s2_r, txw_s3_r;
  logic                   rxd_s1_r, rxd_s2_r, lvl_s1_r, lvl_s2_r;

  logic [WORD_W-1:0]      hold_r, tx_shift_r, tx_shift_dn;
  logic [3:0]             tx_cnt_r;
  logic                   tx_wrap, tx_bit;
  logic                   line_tx_pos_r, line_tx_neg_r;

  logic [WORD_W-1:0]      rx_sr_r, rx_cand, held_r, pres_r, rx_word_r;
  logic [3:0]             rx_cnt_r;
  logic                   rx_bit, sig_ok, comma_hit, rx_done, rise_now, valid, realign;
  logic                   held_comma_r, held_odd_r, pres_comma_r, pres_odd_r;
  logic                   byte_clk_even_r, byte_clk_odd_r, comma_seen_r;
  logic                   line_signal_present_r;

  logic [15:0]            flock_cnt_r;
  logic [11:0]            bsync_cnt_r;
  logic                   locked_r, locked_nxt;

  // pins from outside the clock domain; stage one feeds only stage two
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_s1_r <= 1'b0;
      ref_s2_r <= 1'b0;
      ref_s3_r <= 1'b0;
      txw_s1_r <= '0;
      txw_s2_r <= '0;
      txw_s3_r <= '0;
      rxd_s1_r <= 1'b0;
      rxd_s2_r <= 1'b0;
      lvl_s1_r <= 1'b0;
      lvl_s2_r <= 1'b0;
    end else begin
      ref_s1_r <= reference_clock_in;
      ref_s2_r <= ref_s1_r;
      ref_s3_r <= ref_s2_r;
      txw_s1_r <= tx_word;
      txw_s2_r <= txw_s1_r;
      txw_s3_r <= txw_s2_r;
      rxd_s1_r <= line_rx_data;
      rxd_s2_r <= rxd_s1_r;
      lvl_s1_r <= line_level_ok;
      lvl_s2_r <= lvl_s1_r;
    end
  end

  // txw_s3 is the word as it stood just before the edge, so hold time after the edge is safe
  assign ref_edge = ref_s2_r & ~ref_s3_r; // [RQ11]

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_r <= '0;
    end else if (ref_edge) begin
      hold_r <= txw_s3_r; // [RQ1]
    end
  end

  // free running word frame; latency from capture to first bit varies with frame phase
  assign tx_wrap     = (tx_cnt_r == LAST_BIT);
  assign tx_bit      = tx_shift_r[0];
  assign tx_shift_dn = {1'b0, tx_shift_r[WORD_W-1:1]};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_cnt_r   <= '0;
      tx_shift_r <= '0;
    end else begin
      tx_cnt_r   <= tx_wrap ? 4'h0 : tx_cnt_r + 4'h1;
      tx_shift_r <= tx_wrap ? hold_r : tx_shift_dn; // [RQ2] [RQ7]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || serial_loopback_enable) begin
      line_tx_pos_r <= 1'b1; // [RQ4]
      line_tx_neg_r <= 1'b0;
    end else begin
      line_tx_pos_r <= tx_bit; // [RQ2]
      line_tx_neg_r <= ~tx_bit;
    end
  end

  // receive bit source and word framing
  assign rx_bit    = serial_loopback_enable ? tx_bit : rxd_s2_r; // [RQ3]
  assign sig_ok    = serial_loopback_enable | lvl_s2_r;
  assign rx_cand   = {rx_bit, rx_sr_r[WORD_W-1:1]}; // [RQ13]
  assign comma_hit = comma_align_enable & (rx_cand[COMMA_W-1:0] == COMMA_HEAD); // [RQ14]
  assign rx_done   = (rx_cnt_r == LAST_BIT) | comma_hit; // [RQ15]
  assign rise_now  = (rx_cnt_r == RISE_CNT);
  assign realign   = comma_hit & (rx_cnt_r != LAST_BIT); // [RQ14]
  assign valid     = locked_r & sig_ok;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_sr_r  <= '0;
      rx_cnt_r <= '0;
    end else begin
      rx_sr_r  <= rx_cand;
      rx_cnt_r <= rx_done ? 4'h0 : rx_cnt_r + 4'h1;
    end
  end

  // one word of holding delay sets the latency; commas are flagged only on the odd slot
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      held_r       <= ALL_ONES;
      held_comma_r <= 1'b0;
      held_odd_r   <= 1'b0;
      pres_r       <= ALL_ONES;
      pres_comma_r <= 1'b0;
      pres_odd_r   <= 1'b1; // first presented word rises the odd clock
    end else if (rx_done) begin
      held_r       <= rx_cand;
      held_comma_r <= comma_hit & (realign | ~held_odd_r);
      held_odd_r   <= realign | ~held_odd_r; // [RQ14] [RQ12]
      pres_r       <= held_r;
      pres_comma_r <= held_comma_r;
      pres_odd_r   <= held_odd_r;
    end
  end

  // a realignment may repeat one parity, so one clock skips a rising edge once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byte_clk_even_r <= 1'b1;
      byte_clk_odd_r  <= 1'b0;
    end else if (rise_now) begin
      byte_clk_odd_r  <= pres_odd_r; // [RQ6] [RQ8] [RQ12]
      byte_clk_even_r <= ~pres_odd_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !valid) begin
      rx_word_r <= ALL_ONES; // [RQ5] [RQ10]
    end else if (rise_now) begin
      rx_word_r <= pres_r; // [RQ16]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !valid || !comma_align_enable) begin
      comma_seen_r <= 1'b0; // [RQ15]
    end else if (rise_now) begin
      comma_seen_r <= pres_comma_r; // [RQ14]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      line_signal_present_r <= 1'b0;
    end else begin
      line_signal_present_r <= sig_ok; // [RQ5] [RQ16]
    end
  end

  // lock timers: frequency lock once after reset, bit sync after every signal loss
  assign locked_nxt = (flock_cnt_r == 16'h0000) & (bsync_cnt_r == 12'h000) & sig_ok;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flock_cnt_r <= FLOCK_LOAD;
    end else if (flock_cnt_r != 16'h0000) begin
      flock_cnt_r <= flock_cnt_r - 16'h0001; // [RQ10]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !sig_ok) begin
      bsync_cnt_r <= BSYNC_LOAD; // [RQ9] [RQ16]
    end else if (bsync_cnt_r != 12'h000) begin
      bsync_cnt_r <= bsync_cnt_r - 12'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      locked_r <= 1'b0;
    end else begin
      locked_r <= locked_nxt;
    end
  end

  assign irq_events[IRQ_COMMA_BIT]   = rise_now & pres_comma_r & comma_align_enable & valid;
  assign irq_events[IRQ_SIGLOST_BIT] = line_signal_present_r & ~sig_ok;
  assign irq_events[IRQ_LOCK_BIT]    = locked_nxt & ~locked_r;

  gsp_regs u_regs (
    .clk                    (clk),
    .sys_rst                (sys_rst),
    .s_axi_awaddr           (s_axi_awaddr),
    .s_axi_awvalid          (s_axi_awvalid),
    .s_axi_awready          (s_axi_awready),
    .s_axi_wdata            (s_axi_wdata),
    .s_axi_wstrb            (s_axi_wstrb),
    .s_axi_wvalid           (s_axi_wvalid),
    .s_axi_wready           (s_axi_wready),
    .s_axi_bresp            (s_axi_bresp),
    .s_axi_bvalid           (s_axi_bvalid),
    .s_axi_bready           (s_axi_bready),
    .s_axi_araddr           (s_axi_araddr),
    .s_axi_arvalid          (s_axi_arvalid),
    .s_axi_arready          (s_axi_arready),
    .s_axi_rdata            (s_axi_rdata),
    .s_axi_rresp            (s_axi_rresp),
    .s_axi_rvalid           (s_axi_rvalid),
    .s_axi_rready           (s_axi_rready),
    .sig_present            (line_signal_present_r),
    .locked                 (locked_r),
    .events                 (irq_events),
    .serial_loopback_enable (serial_loopback_enable),
    .comma_align_enable     (comma_align_enable),
    .irq                    (irq)
  );

  assign line_tx_pos         = line_tx_pos_r;
  assign line_tx_neg         = line_tx_neg_r;
  assign rx_word             = rx_word_r;
  assign recv_byte_clk_even  = byte_clk_even_r;
  assign recv_byte_clk_odd   = byte_clk_odd_r;
  assign comma_seen          = comma_seen_r;
  assign line_signal_present = line_signal_present_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_capture;
    ref_edge |=> (hold_r == $past(txw_s3_r));
  endproperty
  a_capture: assert property (p_capture) else $error("holding register missed capture"); // [RQ1]

  property p_lsb_first;
    tx_wrap |=> (tx_shift_r == $past(hold_r)) ##1 (tx_shift_r == $past(tx_shift_dn));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("serial order wrong"); // [RQ2]

  property p_loop_route;
    serial_loopback_enable |=> (rx_sr_r[WORD_W-1] == $past(tx_bit));
  endproperty
  a_loop_route: assert property (p_loop_route) else $error("loopback not routed"); // [RQ3]

  property p_loop_static;
    serial_loopback_enable |=> (line_tx_pos_r && !line_tx_neg_r);
  endproperty
  a_loop_static: assert property (p_loop_static) else $error("line not static one"); // [RQ4]

  property p_los_ones;
    !sig_ok |=> (rx_word_r == ALL_ONES) && !line_signal_present_r;
  endproperty
  a_los_ones: assert property (p_los_ones) else $error("loss of signal not forced"); // [RQ5]

  property p_clk_anti;
    byte_clk_even_r != byte_clk_odd_r;
  endproperty
  a_clk_anti: assert property (p_clk_anti) else $error("byte clocks not opposite"); // [RQ6]

  property p_rx_latency;
    (rx_done && !comma_align_enable) ##1 !realign [*6] |-> ##1 $changed(byte_clk_odd_r);
  endproperty
  a_rx_latency: assert property (p_rx_latency) else $error("byte clock edge late"); // [RQ8]

  property p_resync;
    $rose(sig_ok) |=> !locked_r [*8];
  endproperty
  a_resync: assert property (p_resync) else $error("locked before bit sync"); // [RQ9]

  property p_flock;
    (flock_cnt_r != 16'h0000) |=> (rx_word_r == ALL_ONES) && !locked_r;
  endproperty
  a_flock: assert property (p_flock) else $error("data before frequency lock"); // [RQ10]

  property p_comma_odd;
    comma_seen_r |-> byte_clk_odd_r;
  endproperty
  a_comma_odd: assert property (p_comma_odd) else $error("comma not on odd clock"); // [RQ14]

  property p_comma_off;
    !comma_align_enable |=> !comma_seen_r;
  endproperty
  a_comma_off: assert property (p_comma_off) else $error("comma seen while disabled"); // [RQ15]

endmodule : gsp_serdes_pma
`default_nettype wire

//--- testbench/gsp_host_model.sv
// host coding layer model: reference clock and parallel transmit words
`timescale 1ns/1ps
`default_nettype none
module gsp_host_model (
  // word the bench wants sent
  input  wire logic [9:0] next_word,
  // parallel transmit pins
  output var  logic       reference_clock_in,
  output var  logic [9:0] tx_word
);
  initial begin
    reference_clock_in = 1'b0;
    tx_word = 10'h3FF;
    forever begin
      #40 reference_clock_in = ~reference_clock_in;
      // word moves on the falling edge, well clear of the capture edge
      if (!reference_clock_in) tx_word = next_word;
    end
  end
endmodule : gsp_host_model
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for the gigabit serdes pma block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import gsp_pkg::*;
  logic        clk = 1'b0, sys_rst = 1'b1, line_level_ok = 1'b0, line_rx_data = 1'b0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic        reference_clock_in, line_tx_pos, line_tx_neg, comma_seen, line_signal_present;
  logic        recv_byte_clk_even, recv_byte_clk_odd;
  logic [9:0]  tx_word, rx_word, next_word = 10'h3FF, v;
  int          fails = 0, n_compared = 0;
  integer      seed = 32'h44F8D07B;

  gsp_serdes_pma #(.FLOCK_CYCLES(20)) dut (.*);
  gsp_host_model host (.*);
  initial forever #5 clk = ~clk;
  // external cable: line output returns on the line input
  always @(posedge clk) line_rx_data <= line_tx_pos;

  task automatic end_sim;
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one write or one read; readies are sampled before this edge lands
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= {4{w}};
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_arvalid <= !w;
    s_axi_bready <= w;
    s_axi_rready <= !w;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_bvalid && w) && !(s_axi_rvalid && !w) && n < 50);
    rd = s_axi_rdata;
    rs = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!(w ? s_axi_bvalid : s_axi_rvalid)) begin
      fails++;
      end_sim();
    end
    @(posedge clk);
  endtask : bus

  task automatic wait_hi(ref logic s, input int lim);
    for (int n = 0; n < lim && s !== 1'b1; n++) @(posedge clk);
    if (s !== 1'b1) begin
      fails++;
      end_sim();
    end
  endtask : wait_hi

  // true when the serial bits, earliest first, are a rotation of the word
  function automatic logic is_rot(input logic [9:0] s, input logic [9:0] w);
    for (int k = 0; k < 10; k++) if (10'({s, s} >> k) === w) return 1'b1;
    return 1'b0;
  endfunction : is_rot

  initial begin
    next_word <= 10'($random(seed));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1, 8'h10, 32'h3, q, r);
    chk("unmapped write", 32'(RESP_SLVERR), 32'(r));
    bus(0, CTRL_OFS, 0, q, r);
    chk("ctrl reset", 32'(CTRL_RST), q);
    bus(0, 8'h10, 0, q, r);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    chk("idle word", 32'(ALL_ONES), 32'(rx_word));
    next_word <= {3'($random(seed)), COMMA_HEAD};
    line_level_ok <= 1'b1;
    bus(1, CTRL_OFS, 32'h2, q, r);
    chk("write resp", 32'(RESP_OKAY), 32'(r));
    wait_hi(comma_seen, 3000);
    chk("comma word", 32'(next_word), 32'(rx_word));
    chk("odd clock", 1, 32'(recv_byte_clk_odd));
    chk("clock pair", 32'(!recv_byte_clk_odd), 32'(recv_byte_clk_even));
    for (int k = 0; k < 10; k++) begin
      @(posedge clk);
      v[k] = line_tx_pos;
      chk("neg leg", 32'(!line_tx_pos), 32'(line_tx_neg));
    end
    chk("serial order", 1, 32'(is_rot(v, next_word)));
    bus(0, STATUS_OFS, 0, q, r);
    chk("status locked", 32'h00000003, q);
    // loopback with the outside line dead: data can only come from inside
    bus(1, CTRL_OFS, 32'h3, q, r);
    line_level_ok <= 1'b0;
    for (int k = 0; k < 14; k++) begin
      @(posedge clk);
      if (k > 3) chk("static line", 2, {line_tx_pos, line_tx_neg});
    end
    chk("present in loop", 1, 32'(line_signal_present));
    repeat (40) @(posedge clk);
    wait_hi(comma_seen, 3000);
    chk("loop word", 32'(next_word), 32'(rx_word));
    bus(1, CTRL_OFS, 32'h1, q, r);
    for (int k = 0; k < 30; k++) begin
      @(posedge clk);
      chk("comma off", 0, 32'(comma_seen));
    end
    chk("boundary kept", 32'(next_word), 32'(rx_word));
    bus(1, IRQ_MASK_OFS, 32'h2, q, r);
    bus(1, CTRL_OFS, 32'h2, q, r);
    repeat (4) @(posedge clk);
    chk("present low", 0, 32'(line_signal_present));
    chk("forced ones", 32'(ALL_ONES), 32'(rx_word));
    chk("irq on loss", 1, 32'(irq));
    bus(1, IRQ_STAT_OFS, 32'h7, q, r);
    bus(0, IRQ_STAT_OFS, 0, q, r);
    chk("loss cleared", 0, 32'(q[IRQ_SIGLOST_BIT]));
    chk("irq cleared", 0, 32'(irq));
    line_level_ok <= 1'b1;
    wait_hi(line_signal_present, 8);
    wait_hi(comma_seen, 3000);
    chk("resumed word", 32'(next_word), 32'(rx_word));
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
